// ---- rtl/sar_adc_pkg.sv ----
// Shared constants for the successive-approximation converter control.
// Assumes a single 10 MHz system clock; all times below are in nanoseconds.
package sar_adc_pkg;

  // ---------------------------------------------------------------------------
  // Word format
  // ---------------------------------------------------------------------------
  localparam int RESULT_WIDTH = 12;                       // Bits per conversion result.
  localparam logic [11:0] RESULT_RESET = 12'h000;         // Output latch value after reset.
  localparam logic [11:0] SIGN_FLIP    = 12'h800;         // Bipolar mode inverts the top bit.

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLOCK_KHZ     = 10_000;                  // System clock rate.
  localparam int CONV_TIME_NS  = 1400;                    // Typical conversion time.
  localparam int BIT_PERIOD_NS = CONV_TIME_NS / RESULT_WIDTH;
  // A longest time rounds down, but never below one cycle.
  localparam int BIT_CYCLES_RAW = (BIT_PERIOD_NS * CLOCK_KHZ) / 1_000_000;
  localparam int BIT_CYCLES     = (BIT_CYCLES_RAW < 1) ? 1 : BIT_CYCLES_RAW;

endpackage

// ---- rtl/sar_bit_sequencer.sv ----
// Bit-decision sequencer: internal bit clock divider and the approximation register.
// Assumes the caller only raises start while the sequencer is idle.
module sar_bit_sequencer #(
  parameter int WIDTH      = 12,
  parameter int BIT_CYCLES = 1
) (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic                     start,
  input  wire logic                     comparator_high,
  output logic [WIDTH-1:0]              sar_code,
  output logic [$clog2(WIDTH)-1:0]      bit_index,
  output logic                          bit_tick,
  output logic                          done
);

  localparam int DW = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;
  localparam int IW = $clog2(WIDTH);
  localparam logic [DW-1:0]    DIV_LOAD  = DW'(BIT_CYCLES - 1);
  localparam logic [IW-1:0]    TOP_INDEX = IW'(WIDTH - 1);
  localparam logic [WIDTH-1:0] MSB_TRIAL = {1'b1, {(WIDTH-1){1'b0}}};

  typedef enum logic [0:0] {
    SEQ_IDLE    = 1'b0,
    SEQ_CONVERT = 1'b1
  } seq_state_t;

  seq_state_t       state_q;
  logic [DW-1:0]    div_q;
  logic [IW-1:0]    index_q;
  logic [WIDTH-1:0] sar_q;
  logic             done_q;
  logic             last_bit;

  // A decision is due each time the divider wraps during a conversion.
  assign bit_tick  = (state_q == SEQ_CONVERT) && (div_q == '0);
  assign last_bit  = bit_tick && (index_q == '0);
  assign sar_code  = sar_q;
  assign bit_index = index_q;
  assign done      = done_q;

  // ---------------------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------------------

  // Run state; a start while converting is ignored so nothing restarts midway.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SEQ_IDLE;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          if (start) begin
            state_q <= SEQ_CONVERT;
          end
        end
        SEQ_CONVERT: begin
          if (last_bit) begin
            state_q <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // The bit clock is restarted by every accepted start, so it is phase locked to it.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
    end else if (start && state_q == SEQ_IDLE) begin
      div_q <= DIV_LOAD;
    end else if (state_q == SEQ_CONVERT) begin
      div_q <= bit_tick ? DIV_LOAD : div_q - 1'b1;
    end
  end

  // Bit pointer walks from the top bit down to bit zero.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      index_q <= '0;
    end else if (start && state_q == SEQ_IDLE) begin
      index_q <= TOP_INDEX;
    end else if (bit_tick && index_q != '0) begin
      index_q <= index_q - 1'b1;
    end
  end

  // Register is cleared at start with only the top trial bit set for the first test.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sar_q <= '0;
    end else if (start && state_q == SEQ_IDLE) begin
      sar_q <= MSB_TRIAL;
    end else if (bit_tick) begin
      sar_q[index_q] <= comparator_high;
      if (index_q != '0) begin
        sar_q[index_q - 1'b1] <= 1'b1;
      end
    end
  end

  // One-cycle completion pulse, raised once the last decision is stored.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= last_bit;
    end
  end

endmodule // sar_bit_sequencer

// ---- rtl/sar_adc_conversion_control.sv ----
// Digital control of a 12-bit successive-approximation sampling converter.
// Assumes all host pins are synchronous to clock and the comparator output settles
// within one bit period of the trial code changing.

// Summary of operation
// - Holding power_down_n low puts the converter into its power-saving state.
// - A falling edge on the active-low convert_start_n begins a conversion.
// - Start edges count only while chip select is low, so the host selects first.
// - Result outputs are driven only while read strobe and chip select are both low.
// - busy_n is low for the whole conversion and returns high when it is finished.
// - The result is a 12-bit three-state word whose top bit is the most significant.
// - The approximation register is cleared when a new conversion begins.
// - Start requests during a conversion are ignored and never restart it.
// - Bits are decided one per bit period from the most to the least significant.
// - At the end of a conversion the register is copied into the output latches.
// - No conversion begins while power_down_n is low, even on a start edge.
// - Results are straight binary when unipolar and two's complement when bipolar.
module sar_adc_conversion_control #(
  parameter int WIDTH      = sar_adc_pkg::RESULT_WIDTH,
  parameter int BIT_CYCLES = sar_adc_pkg::BIT_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             chip_select_n,
  input  wire logic             convert_start_n,
  input  wire logic             read_n,
  input  wire logic             power_down_n,
  input  wire logic             bipolar_mode,
  input  wire logic             comparator_high,
  output logic [WIDTH-1:0]      result_bits,
  output logic                  result_oe,
  output logic                  busy_n,
  output logic [WIDTH-1:0]      dac_code,
  output logic                  hold_sample,
  output logic                  powered_down
);

  localparam int IW = $clog2(WIDTH);
  localparam int CONV_CYCLES = WIDTH * BIT_CYCLES + 1;

  logic             start_prev_q;
  logic             start_edge;
  logic             start_accept;
  logic             busy_n_q;
  logic             hold_q;
  logic             powered_down_q;
  logic [WIDTH-1:0] result_q;
  logic [WIDTH-1:0] sar_code;
  logic [IW-1:0]    bit_index;
  logic             bit_tick;
  logic             seq_done;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------

  // Bipolar results are two's complement: the offset-binary top bit is inverted.
  function automatic logic [WIDTH-1:0] to_output_code(input logic [WIDTH-1:0] code,
                                                      input logic             bipolar);
    logic [WIDTH-1:0] flip;
    flip = WIDTH'(sar_adc_pkg::SIGN_FLIP);
    to_output_code = bipolar ? (code ^ flip) : code;
  endfunction

  // ---------------------------------------------------------------------------
  // Start qualification
  // ---------------------------------------------------------------------------

  // Previous level of the start pin; reset high, so a pin held low through reset counts as an edge.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      start_prev_q <= 1'b1;
    end else begin
      start_prev_q <= convert_start_n;
    end
  end

  // Only the falling edge starts; holding the pin low does not retrigger.
  assign start_edge   = start_prev_q && !convert_start_n;
  // Selection, power and idleness must all agree at the edge itself.
  assign start_accept = start_edge && !chip_select_n
                        && power_down_n
                        && busy_n_q;

  // ---------------------------------------------------------------------------
  // Bit sequencer
  // ---------------------------------------------------------------------------

  sar_bit_sequencer #(
    .WIDTH      (WIDTH),
    .BIT_CYCLES (BIT_CYCLES)
  ) u_sequencer (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .start           (start_accept),
    .comparator_high (comparator_high),
    .sar_code        (sar_code),
    .bit_index       (bit_index),
    .bit_tick        (bit_tick),
    .done            (seq_done)
  );

  assign dac_code = sar_code;

  // ---------------------------------------------------------------------------
  // Status and analog control
  // ---------------------------------------------------------------------------

  // Busy drops on acceptance and rises with the latch load, so data is ready with it.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy_n_q <= 1'b1;
    end else if (start_accept) begin
      busy_n_q <= 1'b0;
    end else if (seq_done) begin
      busy_n_q <= 1'b1;
    end
  end

  assign busy_n = busy_n_q;

  // Sample-and-hold tracks whenever idle; this is the acquisition window.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= 1'b0;
    end else if (start_accept) begin
      hold_q <= 1'b1;
    end else if (seq_done) begin
      hold_q <= 1'b0;
    end
  end

  assign hold_sample = hold_q;

  // Power-saving request to the analog section; a running conversion still finishes.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      powered_down_q <= 1'b0;
    end else begin
      powered_down_q <= !power_down_n && busy_n_q;
    end
  end

  assign powered_down = powered_down_q;

  // ---------------------------------------------------------------------------
  // Output latches and read port
  // ---------------------------------------------------------------------------

  // The latches hold the last result, so a read during a conversion sees old data.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      result_q <= WIDTH'(sar_adc_pkg::RESULT_RESET);
    end else if (seq_done) begin
      result_q <= to_output_code(sar_code, bipolar_mode);
    end
  end

  assign result_bits = result_q;
  // Drivers on only while both strobes are low; otherwise the pins float.
  assign result_oe   = !read_n && !chip_select_n;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  // Counts cycles of the current busy-low period.
  logic [7:0] low_count_q;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      low_count_q <= '0;
    end else if (busy_n_q) begin
      low_count_q <= '0;
    end else begin
      low_count_q <= low_count_q + 1'b1;
    end
  end

  chk_power_blocks: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!power_down_n && busy_n) |=> busy_n
  ) else $error("conversion began during power down");

  chk_power_state: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!power_down_n && busy_n) |=> powered_down
  ) else $error("power-saving state not entered");

  chk_start_edge: assert property (
    @(posedge clock) disable iff (sys_rst)
    ($fell(convert_start_n) && !chip_select_n && power_down_n && busy_n) |=> !busy_n
  ) else $error("qualified start edge did not begin a conversion");

  chk_select_gates: assert property (
    @(posedge clock) disable iff (sys_rst)
    (chip_select_n && busy_n) |=> busy_n
  ) else $error("start accepted without chip select");

  chk_read_drive: assert property (
    @(posedge clock) disable iff (sys_rst)
    result_oe |-> (!read_n && !chip_select_n)
  ) else $error("outputs driven without both strobes low");

  chk_float_idle: assert property (
    @(posedge clock) disable iff (sys_rst)
    (read_n || chip_select_n) |-> !result_oe
  ) else $error("outputs driven while deselected");

  chk_busy_length: assert property (
    @(posedge clock) disable iff (sys_rst)
    $rose(busy_n) |-> (low_count_q == 8'(CONV_CYCLES))
  ) else $error("busy low period has the wrong length");

  chk_sar_cleared: assert property (
    @(posedge clock) disable iff (sys_rst)
    start_accept |=> (dac_code == {1'b1, {(WIDTH-1){1'b0}}})
  ) else $error("approximation register not cleared at start");

  chk_no_restart: assert property (
    @(posedge clock) disable iff (sys_rst)
    (!busy_n && bit_tick && bit_index != '0) |=> (!busy_n && bit_index == $past(bit_index) - 1'b1)
  ) else $error("conversion restarted or skipped a bit");

  chk_trial_order: assert property (
    @(posedge clock) disable iff (sys_rst)
    (hold_sample && !seq_done) |-> (dac_code[bit_index]
      && ((dac_code & ((WIDTH'(1) << bit_index) - 1'b1)) == '0))
  ) else $error("trial bit is not the lowest set bit");

  chk_latch_load: assert property (
    @(posedge clock) disable iff (sys_rst)
    seq_done |=> (result_bits == ($past(dac_code)
      ^ ($past(bipolar_mode) ? WIDTH'(sar_adc_pkg::SIGN_FLIP) : '0)))
  ) else $error("result latch not loaded with the finished code");

  chk_latch_holds: assert property (
    @(posedge clock) disable iff (sys_rst)
    !seq_done |=> $stable(result_bits)
  ) else $error("result changed without a finished conversion");

endmodule // sar_adc_conversion_control

// ---- testbench/sar_comparator_model.sv ----
// Behavioural comparator standing behind the trial-code outputs of the converter control.
// Assumes a target code set by the bench stands for the held analog input.
module sar_comparator_model (
  input  wire logic        clock,
  input  wire logic        hold_sample,
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] target,
  output logic             comparator_high
);
  timeunit 1ns;
  timeprecision 100ps;

  // Initialised at its declaration so that the clocked process stays its only driver.
  logic toggle_q = 1'b0;

  // ---------------------------------------------------------------------------
  // Decision
  // ---------------------------------------------------------------------------
  // Outside a hold the comparator is tracking, so its output is noise; a toggling
  // pattern stops the control from getting away with sampling it there.
  always_ff @(posedge clock) begin
    toggle_q <= ~toggle_q;
  end

  // Keep the trial bit while the held input is not below the trial code.
  assign comparator_high = hold_sample ? (dac_code <= target) : toggle_q;

endmodule // sar_comparator_model

// ---- testbench/tb_sar_adc_conversion_control.sv ----
// Self-checking bench for the converter control, acting as the host.
// Assumes the comparator model file and the design files are compiled before this one.
module tb_sar_adc_conversion_control;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int BIT_CYC = 1;
  localparam int LOW_CYC = 12 * BIT_CYC + 1;

  logic        clock;
  logic        sys_rst;
  logic        chip_select_n;
  logic        convert_start_n;
  logic        read_n;
  logic        power_down_n;
  logic        bipolar_mode;
  logic        comparator_high;
  logic [11:0] result_bits;
  logic        result_oe;
  logic        busy_n;
  logic [11:0] dac_code;
  logic        hold_sample;
  logic        powered_down;
  logic [11:0] target;
  wire  [11:0] data_bus;
  int          bad_count;
  int          total_checks;
  int          cycles;

  // The three-state result pins as seen on the host bus.
  assign data_bus = result_oe ? result_bits : 12'hzzz;

  sar_adc_conversion_control #(.WIDTH(12), .BIT_CYCLES(BIT_CYC)) i_sar_adc_conversion_control (
    .clock(clock), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .convert_start_n(convert_start_n), .read_n(read_n), .power_down_n(power_down_n),
    .bipolar_mode(bipolar_mode), .comparator_high(comparator_high),
    .result_bits(result_bits), .result_oe(result_oe), .busy_n(busy_n), .dac_code(dac_code),
    .hold_sample(hold_sample), .powered_down(powered_down));

  sar_comparator_model i_sar_comparator_model (
    .clock(clock), .hold_sample(hold_sample), .dac_code(dac_code), .target(target),
    .comparator_high(comparator_high));

  // ---------------------------------------------------------------------------
  // Clock, timeout and reporting
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // A full run needs well under a thousand cycles; the ceiling leaves ample margin.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs always move a fixed delay after the rising edge.
  task automatic step();
    @(posedge clock);
    #10;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // One accepted conversion; optionally hammers the start pin while busy.
  task automatic conv(input logic [11:0] tgt, input logic bip, input logic hammer);
    int n;
    target = tgt;
    bipolar_mode = bip;
    convert_start_n = 1'b0;
    step();
    n = 0;
    while (busy_n !== 1'b0 && n < 3) begin
      step();
      n++;
    end
    check(busy_n, 1'b0);
    check(dac_code, 12'h800);
    check(hold_sample, 1'b1);
    step();
    check(dac_code, (tgt & 12'h800) | 12'h400);
    n = 2;
    while (busy_n === 1'b0 && n < 40) begin
      if (hammer) convert_start_n = ~convert_start_n;
      step();
      if (busy_n === 1'b0) n++;
    end
    check(12'(n), 12'(LOW_CYC));
    check(result_bits, bip ? (tgt ^ 12'h800) : tgt);
    check(hold_sample, 1'b0);
    // Three idle cycles leave over 300 ns of acquisition and put 17 cycles between
    // accepted starts; two would run the converter at 625 kHz, above the ceiling.
    convert_start_n = 1'b1;
    step();
    step();
    step();
  endtask

  // Every strobe pairing; only both low may drive the bus.
  task automatic read_all(input logic [11:0] exp);
    for (int i = 0; i < 4; i++) begin
      {chip_select_n, read_n} = 2'(i);
      #20;
      check(result_oe, i == 0);
      check(data_bus, (i == 0) ? exp : 12'hzzz);
      step();
    end
    chip_select_n = 1'b0;
    read_n = 1'b1;
  endtask

  // A start edge must be ignored: busy stays high throughout.
  task automatic refused_start();
    convert_start_n = 1'b0;
    repeat (4) begin
      step();
      check(busy_n, 1'b1);
    end
    convert_start_n = 1'b1;
    step();
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    chip_select_n = 1'b0;
    convert_start_n = 1'b1;
    read_n = 1'b1;
    power_down_n = 1'b1;
    bipolar_mode = 1'b0;
    target = 12'h000;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    #10;
    sys_rst = 1'b0;
    step();
    check(busy_n, 1'b1);
    check(result_bits, 12'h000);
    check(powered_down, 1'b0);
    conv(12'ha5c, 1'b0, 1'b0);
    read_all(12'ha5c);
    conv(12'hfff, 1'b0, 1'b1);
    conv(12'h000, 1'b1, 1'b0);
    read_all(12'h800);
    conv(12'h7ff, 1'b1, 1'b0);
    chip_select_n = 1'b1;
    refused_start();
    chip_select_n = 1'b0;
    power_down_n = 1'b0;
    step();
    step();
    check(powered_down, 1'b1);
    refused_start();
    power_down_n = 1'b1;
    repeat (4) step();
    check(powered_down, 1'b0);
    conv(12'h001, 1'b0, 1'b0);
    test_done();
  end
endmodule // tb_sar_adc_conversion_control
